// file: rtl/twr_defines.svh
// constants of the two-wire receiver controller: offsets, codes, timing
`ifndef TWR_DEFINES_SVH
`define TWR_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TWR_OFS_DATA 8'h00
`define TWR_OFS_STAT 8'h04
`define TWR_OFS_OWN 8'h08
`define TWR_OFS_CTRL 8'h0C

// ****************************************************************
// reset values
// ****************************************************************
`define TWR_CTRL_RST 8'h00
`define TWR_OWN_RST 8'h00
`define TWR_DATA_RST 8'hFF

// ****************************************************************
// status codes, prescaler bits excluded
// ****************************************************************
`define TWR_ST_START 8'h08
`define TWR_ST_RSTART 8'h10
`define TWR_ST_AW_ACK 8'h18
`define TWR_ST_AW_NACK 8'h20
`define TWR_ST_DT_ACK 8'h28
`define TWR_ST_DT_NACK 8'h30
`define TWR_ST_ARB 8'h38
`define TWR_ST_AR_ACK 8'h40
`define TWR_ST_AR_NACK 8'h48
`define TWR_ST_DR_ACK 8'h50
`define TWR_ST_DR_NACK 8'h58
`define TWR_ST_SW_ADR 8'h60
`define TWR_ST_SW_ARB 8'h68
`define TWR_ST_GC_ADR 8'h70
`define TWR_ST_GC_ARB 8'h78
`define TWR_ST_SD_ACK 8'h80
`define TWR_ST_SD_NACK 8'h88
`define TWR_ST_GD_ACK 8'h90
`define TWR_ST_GD_NACK 8'h98
`define TWR_ST_SR_ADR 8'hA8
`define TWR_ST_SR_ARB 8'hB0
`define TWR_ST_ST_ACK 8'hB8
`define TWR_ST_ST_NACK 8'hC0
`define TWR_ST_IDLE 8'hF8

// ****************************************************************
// timing: half period of the generated bus clock
// ****************************************************************
`define TWR_HALF_NS 2500
`define TWR_CLK_MHZ 40
`define TWR_HALF_CYC ((`TWR_HALF_NS * `TWR_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/twr_pkg.sv
// types of the two-wire receiver controller
package twr_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_FREE, S_START, S_XFER, S_HOLD, S_STOP
  } twr_fsm_t;

  typedef enum logic [2:0] {
    R_DATA, R_STAT, R_OWN, R_CTRL, R_NONE
  } twr_reg_t;

  typedef struct packed {
    logic done;
    logic ack_en;
    logic start_bit_field;
    logic stop_bit_field;
    logic wcol;
    logic en;
    logic rsvd;
    logic irq_en;
  } twr_ctrl_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    twr_fsm_t fsm;
    logic [1:0] step;
    logic [7:0] tmr;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic tx;
    logic master;
    logic slave;
    logic gc;
    logic arb;
    logic addr_ph;
    logic ack_out;
    logic got_ack;
    logic busy;
    logic rs;
    logic scl_low;
    logic sda_low;
    logic wake;
    twr_ctrl_t ctrl;
    logic [7:0] own;
    logic [7:0] data;
    logic [7:0] stat;
    logic [1:0] pre;
    logic [7:0] ahb_addr;
    logic ahb_wr;
    logic [31:0] hrdata;
  } twr_state_t;

endpackage

// file: rtl/twr_ctrl.sv
// two-wire controller: master receiver and slave receiver, AHB-Lite regs
`timescale 1ns/1ps
`include "twr_defines.svh"

// How it works
// [RQ1] at 08 send loaded read address, sample ack
// [RQ2] at 10 send read or write address
// [RQ3] at 38 release bus or start when free
// [RQ4] at 40/50 receive byte, ack per ack_enable
// [RQ5] at 48 restart, stop, or stop then start
// [RQ6] at 58 restart, stop, or stop then start
// [RQ7] hardware clears stop_request on every stop sent
// [RQ8] status codes compare with prescaler bits masked
// [RQ9] upper seven own address bits are slave address
// [RQ10] general_call_enable enables answering address 00
// [RQ11] software sets enable and ack for slave receive
// [RQ12] direction bit 0 slave receive, else transmit
// [RQ13] own address with write sets flag and status
// [RQ14] arbitration lost then addressed reports 68 or 78
// [RQ15] ack_enable cleared gives not-ack after next byte
// [RQ16] ack_enable low ignores own address, keeps monitoring
// [RQ17] deep sleep address match acks, wakes, stretches
// [RQ18] writing one clears flag and releases clock
// [RQ19] data register not updated while deeply asleep
// [RQ20] clock line held low while flag is set; code leaves it released at 38, as neither master nor slave
module twr_ctrl (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // two-wire bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // power management
  input wire logic deep_sleep,
  output logic wake_req
);

  localparam logic [7:0] HALF_END = 8'(`TWR_HALF_CYC - 1);
  localparam twr_pkg::twr_state_t RST = '{
    fsm: twr_pkg::S_IDLE, stat: `TWR_ST_IDLE, ctrl: `TWR_CTRL_RST,
    own: `TWR_OWN_RST, data: `TWR_DATA_RST, default: '0};

  twr_pkg::twr_state_t r_q;
  twr_pkg::twr_state_t r_d;

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic twr_pkg::twr_reg_t reg_sel(input logic [7:0] a);
    twr_pkg::twr_reg_t s;
    s = twr_pkg::R_NONE;
    case (a)
      `TWR_OFS_DATA: s = twr_pkg::R_DATA;
      `TWR_OFS_STAT: s = twr_pkg::R_STAT;
      `TWR_OFS_OWN: s = twr_pkg::R_OWN;
      `TWR_OFS_CTRL: s = twr_pkg::R_CTRL;
      default: s = twr_pkg::R_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [31:0] rd_val(input twr_pkg::twr_reg_t s,
                                         input twr_pkg::twr_state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (s)
      twr_pkg::R_DATA: v = {24'h00_0000, st.data};
      twr_pkg::R_STAT: v = {24'h00_0000, st.stat[7:3], 1'b0, st.pre};
      twr_pkg::R_OWN: v = {24'h00_0000, st.own};
      twr_pkg::R_CTRL: v = {24'h00_0000, st.ctrl};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic half_done;
  logic go;
  logic own_hit;
  logic gc_hit;
  logic [7:0] code;

  // edges are taken from the second sync stage onward only
  assign scl_rise = r_q.scl_s & ~r_q.scl_p;
  assign scl_fall = ~r_q.scl_s & r_q.scl_p;
  assign start_ev = r_q.scl_s & r_q.scl_p & r_q.sda_p & ~r_q.sda_s;
  assign stop_ev = r_q.scl_s & r_q.scl_p & ~r_q.sda_p & r_q.sda_s;
  assign half_done = r_q.tmr == HALF_END;
  assign own_hit = r_q.sh[7:1] == r_q.own[7:1]; // RQ9
  assign gc_hit = (r_q.sh == 8'h00) & r_q.own[0]; // RQ10
  // codes compared without the prescaler bits
  assign code = {r_q.stat[7:3], 3'h0}; // RQ8

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    r_d = r_q;
    go = 1'b0;
    r_d.scl_m = scl_i;
    r_d.scl_s = r_q.scl_m;
    r_d.scl_p = r_q.scl_s;
    r_d.sda_m = sda_i;
    r_d.sda_s = r_q.sda_m;
    r_d.sda_p = r_q.sda_s;

    // bus data phase writes
    if (r_q.ahb_wr) begin
      unique case (reg_sel(r_q.ahb_addr))
        twr_pkg::R_DATA: begin
          // writing data while the engine owns it is flagged, not applied
          if (r_q.ctrl.done) begin
            r_d.data = hwdata[7:0];
            r_d.ctrl.wcol = 1'b0;
          end else begin
            r_d.ctrl.wcol = 1'b1;
          end
        end
        twr_pkg::R_STAT: r_d.pre = hwdata[1:0];
        twr_pkg::R_OWN: r_d.own = hwdata[7:0];
        twr_pkg::R_CTRL: begin
          r_d.ctrl.ack_en = hwdata[6];
          r_d.ctrl.start_bit_field = hwdata[5];
          r_d.ctrl.stop_bit_field = hwdata[4];
          r_d.ctrl.en = hwdata[2];
          r_d.ctrl.irq_en = hwdata[0];
          if (hwdata[7]) begin
            r_d.ctrl.done = 1'b0; // RQ18
            go = 1'b1;
          end
        end
        twr_pkg::R_NONE: r_d.ctrl = r_d.ctrl;
      endcase
    end

    // bus address phase; read data captured here, zero wait states
    r_d.ahb_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      r_d.ahb_addr = haddr[7:0];
      r_d.ahb_wr = hwrite;
      if (!hwrite) begin
        r_d.hrdata = rd_val(reg_sel(haddr[7:0]), r_q);
      end
    end

    if (start_ev) begin
      r_d.busy = 1'b1;
    end
    if (stop_ev) begin
      r_d.busy = 1'b0;
    end
    if (!deep_sleep) begin
      r_d.wake = 1'b0;
    end

    unique case (r_q.fsm)
      twr_pkg::S_IDLE, twr_pkg::S_WAIT_FREE: begin
        r_d.scl_low = 1'b0;
        r_d.sda_low = 1'b0;
        if (r_q.fsm == twr_pkg::S_IDLE && r_q.ctrl.start_bit_field && !r_q.ctrl.done) begin
          r_d.fsm = twr_pkg::S_WAIT_FREE;
        end
        // slave logic keeps listening even with ack disabled
        if (start_ev) begin // RQ16
          r_d.fsm = twr_pkg::S_XFER;
          r_d.bitcnt = 4'hF;
          r_d.addr_ph = 1'b1;
          r_d.tx = 1'b0;
          r_d.slave = 1'b0;
          r_d.gc = 1'b0;
          r_d.arb = 1'b0;
        end else if (r_q.fsm == twr_pkg::S_WAIT_FREE && !r_q.busy &&
                     r_q.scl_s && r_q.sda_s) begin
          r_d.fsm = twr_pkg::S_START; // RQ3
          r_d.master = 1'b1;
          r_d.rs = 1'b0;
          r_d.step = 2'd0;
          r_d.tmr = 8'h00;
        end
      end

      twr_pkg::S_START: begin
        r_d.tmr = half_done ? 8'h00 : r_q.tmr + 8'h01;
        unique case (r_q.step)
          2'd2: begin
            r_d.sda_low = 1'b0;
            if (half_done) begin
              r_d.scl_low = 1'b0;
              r_d.step = 2'd3;
            end
          end
          2'd3: begin
            // wait for the clock really high; slaves may stretch it
            if (!r_q.scl_s) begin
              r_d.tmr = 8'h00;
            end else if (half_done) begin
              r_d.step = 2'd0;
            end
          end
          2'd0: begin
            r_d.sda_low = 1'b1;
            if (half_done) begin
              r_d.step = 2'd1;
            end
          end
          2'd1: begin
            r_d.scl_low = 1'b1;
            if (half_done) begin
              r_d.stat = r_q.rs ? `TWR_ST_RSTART : `TWR_ST_START;
              r_d.ctrl.done = 1'b1;
              r_d.fsm = twr_pkg::S_HOLD;
            end
          end
        endcase
      end

      twr_pkg::S_XFER: begin
        // master clock generator, low half then high half
        if (r_q.master) begin
          r_d.tmr = half_done ? 8'h00 : r_q.tmr + 8'h01;
          if (r_q.step == 2'd0) begin
            if (half_done) begin
              r_d.scl_low = 1'b0;
              r_d.step = 2'd1;
            end
          end else if (!r_q.scl_s) begin
            r_d.tmr = 8'h00;
          end else if (half_done) begin
            r_d.scl_low = 1'b1;
            r_d.step = 2'd0;
          end
        end
        if (scl_rise) begin
          if (r_q.bitcnt < 4'h8) begin
            r_d.sh = {r_q.sh[6:0], r_q.sda_s};
            // sent a one, saw a zero: another master wins
            if (r_q.tx && r_q.master && !r_q.sda_low && !r_q.sda_s) begin
              r_d.master = 1'b0;
              r_d.arb = 1'b1;
              r_d.tx = 1'b0;
              r_d.scl_low = 1'b0;
            end
          end else begin
            r_d.got_ack = ~r_q.sda_s;
            if (r_q.master && !r_q.tx && !r_q.sda_low && !r_q.sda_s) begin
              r_d.master = 1'b0;
              r_d.arb = 1'b1;
              r_d.scl_low = 1'b0;
            end
          end
        end
        if (scl_fall) begin
          if (r_q.bitcnt < 4'h7) begin
            r_d.bitcnt = r_q.bitcnt + 4'h1;
            r_d.sda_low = r_q.tx & ~r_q.sh[7];
          end else if (r_q.bitcnt == 4'h7) begin
            r_d.bitcnt = 4'h8;
            r_d.sda_low = 1'b0;
            if (!deep_sleep) begin
              r_d.data = r_q.sh; // RQ19
            end
            if (r_q.tx) begin
              r_d.sda_low = 1'b0;
            end else if (r_q.addr_ph && !r_q.master) begin
              if (r_q.ctrl.ack_en && (own_hit || gc_hit)) begin // RQ16
                r_d.sda_low = 1'b1;
                r_d.slave = 1'b1;
                r_d.gc = gc_hit & ~own_hit;
                r_d.wake = deep_sleep; // RQ17
              end else if (r_q.arb) begin
                r_d.stat = `TWR_ST_ARB;
                r_d.ctrl.done = 1'b1;
                r_d.fsm = twr_pkg::S_HOLD;
              end else begin
                r_d.fsm = twr_pkg::S_IDLE;
              end
            end else begin
              // ack_enable looked at only when the ack is driven
              r_d.sda_low = r_q.ctrl.ack_en; // RQ4 RQ15
              r_d.ack_out = r_q.ctrl.ack_en;
            end
          end else if (r_q.bitcnt == 4'hF) begin
            // this fall ends the start condition, not a bit
            r_d.bitcnt = 4'h0;
          end else begin
            r_d.sda_low = 1'b0;
            r_d.bitcnt = 4'h0;
            r_d.addr_ph = 1'b0;
            r_d.ctrl.done = 1'b1; // RQ13
            r_d.fsm = twr_pkg::S_HOLD;
            r_d.tmr = 8'h00;
            r_d.step = 2'd0;
            r_d.scl_low = r_q.master | r_q.slave; // RQ20
            if (r_q.master && r_q.addr_ph) begin
              if (r_q.sh[0]) begin
                r_d.stat = r_q.got_ack ? `TWR_ST_AR_ACK : `TWR_ST_AR_NACK;
              end else begin
                r_d.stat = r_q.got_ack ? `TWR_ST_AW_ACK : `TWR_ST_AW_NACK;
              end
            end else if (r_q.master) begin
              if (r_q.tx) begin
                r_d.stat = r_q.got_ack ? `TWR_ST_DT_ACK : `TWR_ST_DT_NACK;
              end else begin
                r_d.stat = r_q.ack_out ? `TWR_ST_DR_ACK : `TWR_ST_DR_NACK;
              end
            end else if (!r_q.slave) begin
              r_d.stat = `TWR_ST_ARB;
            end else if (r_q.addr_ph) begin
              // direction bit picks receive or transmit
              if (r_q.sh[0]) begin // RQ12
                r_d.stat = r_q.arb ? `TWR_ST_SR_ARB : `TWR_ST_SR_ADR;
              end else if (r_q.gc) begin
                r_d.stat = r_q.arb ? `TWR_ST_GC_ARB : `TWR_ST_GC_ADR; // RQ14
              end else begin
                r_d.stat = r_q.arb ? `TWR_ST_SW_ARB : `TWR_ST_SW_ADR; // RQ14
              end
            end else if (r_q.tx) begin
              r_d.stat = r_q.got_ack ? `TWR_ST_ST_ACK : `TWR_ST_ST_NACK;
            end else if (r_q.gc) begin
              r_d.stat = r_q.ack_out ? `TWR_ST_GD_ACK : `TWR_ST_GD_NACK;
            end else begin
              r_d.stat = r_q.ack_out ? `TWR_ST_SD_ACK : `TWR_ST_SD_NACK;
            end
          end
        end
        // a new start restarts address reception; a stop ends slave work
        if (!r_q.master && start_ev) begin
          r_d.bitcnt = 4'hF;
          r_d.addr_ph = 1'b1;
          r_d.tx = 1'b0;
          r_d.slave = 1'b0;
          r_d.gc = 1'b0;
          r_d.sda_low = 1'b0;
        end else if (!r_q.master && stop_ev) begin
          r_d.fsm = twr_pkg::S_IDLE;
          r_d.slave = 1'b0;
        end
      end

      twr_pkg::S_HOLD: begin
        r_d.scl_low = r_q.master | r_q.slave; // RQ17 RQ20
        if (go) begin
          r_d.bitcnt = 4'h0;
          r_d.tmr = 8'h00;
          r_d.step = 2'd0;
          r_d.fsm = twr_pkg::S_XFER;
          case (code)
            `TWR_ST_START, `TWR_ST_RSTART: begin
              // address byte taken from data, read or write
              r_d.sh = r_q.data; // RQ1 RQ2
              r_d.tx = 1'b1;
              r_d.addr_ph = 1'b1;
              r_d.sda_low = ~r_q.data[7];
            end
            `TWR_ST_AR_ACK, `TWR_ST_DR_ACK: begin
              r_d.tx = 1'b0; // RQ4
              r_d.sda_low = 1'b0;
            end
            `TWR_ST_AW_ACK, `TWR_ST_AW_NACK, `TWR_ST_DT_ACK,
            `TWR_ST_DT_NACK, `TWR_ST_AR_NACK, `TWR_ST_DR_NACK: begin
              if (r_d.ctrl.stop_bit_field) begin
                r_d.fsm = twr_pkg::S_STOP; // RQ5 RQ6
              end else if (r_d.ctrl.start_bit_field) begin
                r_d.fsm = twr_pkg::S_START; // RQ5 RQ6
                r_d.rs = 1'b1;
                r_d.step = 2'd2;
              end else begin
                r_d.sh = r_q.data;
                r_d.tx = 1'b1;
                r_d.sda_low = ~r_q.data[7];
              end
            end
            `TWR_ST_SW_ADR, `TWR_ST_SW_ARB, `TWR_ST_GC_ADR, `TWR_ST_GC_ARB,
            `TWR_ST_SD_ACK, `TWR_ST_GD_ACK: begin
              r_d.tx = 1'b0;
              r_d.scl_low = 1'b0;
            end
            `TWR_ST_SR_ADR, `TWR_ST_SR_ARB, `TWR_ST_ST_ACK: begin
              r_d.sh = r_q.data;
              r_d.tx = 1'b1;
              r_d.sda_low = ~r_q.data[7];
              r_d.scl_low = 1'b0;
            end
            default: begin
              // arbitration lost or not-ack given or received as slave: step aside
              r_d.fsm = r_d.ctrl.start_bit_field ? twr_pkg::S_WAIT_FREE : twr_pkg::S_IDLE;
              r_d.master = 1'b0; // RQ3
              r_d.slave = 1'b0;
              r_d.gc = 1'b0;
              r_d.arb = 1'b0;
              r_d.scl_low = 1'b0;
              r_d.sda_low = 1'b0;
            end
          endcase
        end
      end

      twr_pkg::S_STOP: begin
        r_d.tmr = half_done ? 8'h00 : r_q.tmr + 8'h01;
        unique case (r_q.step)
          2'd0: begin
            r_d.sda_low = 1'b1;
            if (half_done) begin
              r_d.scl_low = 1'b0;
              r_d.step = 2'd1;
            end
          end
          2'd1: begin
            if (!r_q.scl_s) begin
              r_d.tmr = 8'h00;
            end else if (half_done) begin
              r_d.sda_low = 1'b0;
              r_d.step = 2'd2;
            end
          end
          default: begin
            // bus free time before a following start
            if (half_done) begin
              r_d.ctrl.stop_bit_field = 1'b0; // RQ7
              r_d.master = 1'b0;
              r_d.fsm = r_q.ctrl.start_bit_field ? twr_pkg::S_WAIT_FREE
                                     : twr_pkg::S_IDLE;
            end
          end
        endcase
      end
    endcase

    if (!r_d.ctrl.en) begin
      r_d.fsm = twr_pkg::S_IDLE;
      r_d.master = 1'b0;
      r_d.slave = 1'b0;
      r_d.scl_low = 1'b0;
      r_d.sda_low = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_q <= RST;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata = r_q.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign scl_o = 1'b0;
  assign scl_oe = r_q.scl_low;
  assign sda_o = 1'b0;
  assign sda_oe = r_q.sda_low;
  assign wake_req = r_q.wake;

endmodule // twr_ctrl

// file: sim/twr_ctrl_monitor.sv
// port relations of the two-wire controller, bound to its top module
`timescale 1ns/1ps
module twr_ctrl_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and power
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic deep_sleep,
  input wire logic wake_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay)
    else $error("bus answer not ready or not okay");
  property p_od; !scl_o && !sda_o; endproperty
  a_od: assert property (p_od)
    else $error("open drain pin drives high");
  property p_wake_src; $rose(wake_req) |-> deep_sleep; endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("wake request outside deep sleep");
  property p_wake_hold; $rose(wake_req) |-> ##[0:40] scl_oe; endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("clock not held after wake match");
  property p_wake_end;
    $fell(deep_sleep) |-> ##[0:2] !wake_req;
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("wake request stays after wake up");
  // read data only moves after a read address phase
  property p_rd_hold; !$past(rd_take) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_hi_zero; rd_take |=> hrdata[31:8] == 24'h0; endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper read bits not zero");
  property p_unmapped;
    rd_take && haddr[7:0] > 8'h0C |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_stat_fmt;
    rd_take && haddr[7:0] == 8'h04 |=> !hrdata[2];
  endproperty
  a_stat_fmt: assert property (p_stat_fmt)
    else $error("status bit two not zero");
  property p_ctrl_rsvd;
    rd_take && haddr[7:0] == 8'h0C |=> !hrdata[1];
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("reserved control bit set");
  c_stat: cover property (rd_take && haddr[7:0] == 8'h04);
  c_wake: cover property ($rose(wake_req));
  c_hold: cover property ($rose(scl_oe));
endmodule // twr_ctrl_monitor

bind twr_ctrl twr_ctrl_monitor twr_ctrl_monitor_inst (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .scl_o, .scl_oe, .sda_o, .deep_sleep, .wake_req);

// file: sim/twr_bus_model.sv
// far-side master on the two wires; pull-ups make released lines high
`timescale 1ns/1ps
module twr_bus_model (
  // resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-downs of this model
  output logic scl_dn = 1'h0,
  output logic sda_dn = 1'h0
);
  // bounded wait while the slave stretches the clock
  task automatic scl_up();
    scl_dn = 1'h0;
    for (int i = 0; i < 4000 && scl !== 1'h1; i++) #25;
    #100;
  endtask
  task automatic start();
    sda_dn = 1'h1;
    #100;
    scl_dn = 1'h1;
    #50;
  endtask
  task automatic stop();
    sda_dn = 1'h1;
    #50;
    scl_up();
    sda_dn = 1'h0;
    #100;
  endtask
  // data moves only while the clock is low; ack level seen in slot nine
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_dn = !b[i];
      #50;
      scl_up();
      scl_dn = 1'h1;
      #50;
    end
    sda_dn = 1'h0;
    #50;
    scl_up();
    ack = sda;
    scl_dn = 1'h1;
    #50;
  endtask
endmodule // twr_bus_model

// file: sim/tb.sv
// bench: register bus master, far-side model and scenarios
`timescale 1ns/1ps
module tb;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic deep_sleep = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, wake_req;
  logic scl_dn, sda_dn, ack;
  logic [7:0] q;
  wire scl = !(scl_oe || scl_dn);
  wire sda = !(sda_oe || sda_dn);
  int err_total = 0, total_checks = 0;
  always #12.5 hclk = !hclk;
  twr_ctrl twr_ctrl_inst (.hclk, .hresetn, .ce(1'h1), .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
    .sda_oe, .deep_sleep, .wake_req);
  twr_bus_model twr_bus_model_inst (.scl, .sda, .scl_dn, .sda_dn);
  // ****************************************************************
  // common tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d,
      output logic [7:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 20);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 20);
    r = hrdata[7:0];
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] r;
    bus(1'h1, a, d, r);
  endtask
  task automatic rchk(input logic [7:0] a, e);
    logic [7:0] r;
    bus(1'h0, a, 8'h00, r);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // polls control until the bit shows the level, bounded
  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 1500; i++) begin
      bus(1'h0, 8'h0C, 8'h00, q);
      if (q[b] === v) return;
    end
    $display("Error wait on control bit %0d", b);
    err_total++;
    give_verdict();
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk(8'h00, 8'hFF);
    rchk(8'h04, 8'hF8);
    rchk(8'h08, 8'h00);
    rchk(8'h0C, 8'h00);
    rchk(8'h10, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_slave();
    wr(8'h08, 8'h55);
    wr(8'h0C, 8'h44);
    wr(8'h00, 8'h33);
    rchk(8'h0C, 8'h4C);
    rchk(8'h00, 8'hFF);
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h56, ack);
    chk("nack foreign", {7'h0, ack}, 8'h01);
    twr_bus_model_inst.stop();
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h54, ack);
    chk("ack own", {7'h0, ack}, 8'h00);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h60);
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    wr(8'h0C, 8'hC4);
    rchk(8'h04, 8'h60);
    chk("scl freed", {7'h0, scl_oe}, 8'h00);
    twr_bus_model_inst.put_byte(8'hA5, ack);
    chk("ack data", {7'h0, ack}, 8'h00);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h80);
    rchk(8'h00, 8'hA5);
    wr(8'h0C, 8'h84);
    twr_bus_model_inst.put_byte(8'h3C, ack);
    chk("nack data", {7'h0, ack}, 8'h01);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h88);
    rchk(8'h00, 8'h3C);
    wr(8'h0C, 8'h84);
    twr_bus_model_inst.stop();
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h54, ack);
    chk("isolated", {7'h0, ack}, 8'h01);
    twr_bus_model_inst.stop();
    wr(8'h0C, 8'hC4);
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h00, ack);
    chk("ack general", {7'h0, ack}, 8'h00);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h70);
    wr(8'h0C, 8'hC4);
    twr_bus_model_inst.stop();
    wr(8'h08, 8'h54);
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h00, ack);
    chk("no general", {7'h0, ack}, 8'h01);
    twr_bus_model_inst.stop();
    $display("test slave done");
  endtask
  task automatic t_sleep();
    @(posedge hclk);
    deep_sleep <= 1'h1;
    twr_bus_model_inst.start();
    twr_bus_model_inst.put_byte(8'h54, ack);
    chk("ack asleep", {7'h0, ack}, 8'h00);
    wait_bit(7, 1'h1);
    chk("wake", {7'h0, wake_req}, 8'h01);
    chk("scl held", {7'h0, scl_oe}, 8'h01);
    @(posedge hclk);
    deep_sleep <= 1'h0;
    wr(8'h0C, 8'hC4);
    rchk(8'h00, 8'h00);
    chk("scl freed", {7'h0, scl_oe}, 8'h00);
    twr_bus_model_inst.stop();
    $display("test sleep done");
  endtask
  task automatic t_master();
    wr(8'h04, 8'h03);
    wr(8'h0C, 8'hA4);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h0B);
    wr(8'h00, 8'hA1);
    wr(8'h0C, 8'h84);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h4B);
    wr(8'h0C, 8'hA4);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h13);
    wr(8'h00, 8'hA1);
    wr(8'h0C, 8'h84);
    wait_bit(7, 1'h1);
    rchk(8'h04, 8'h4B);
    wr(8'h0C, 8'h94);
    wait_bit(4, 1'h0);
    repeat (250) @(posedge hclk);
    chk("bus free", {6'h0, scl_oe, sda_oe}, 8'h00);
    chk("lines high", {6'h0, scl, sda}, 8'h03);
    $display("test master done");
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_slave();
    t_sleep();
    t_master();
    give_verdict();
  end
endmodule // tb
